//--- pkg/rst_seq_consts.svh
// Constants for the display hardware reset sequencer.
// Assumes a 10 MHz system clock; included by its bare name.
`ifndef RST_SEQ_CONSTS_SVH
`define RST_SEQ_CONSTS_SVH

// ****************************************
// Clock and pin filter timing
// ****************************************
`define RSEQ_CLK_NS 100
`define RSEQ_REJECT_US 5
`define RSEQ_ACCEPT_US 9
`define RSEQ_FILTER_US 7
`define RSEQ_REJECT_CYC ((`RSEQ_REJECT_US * 1000 + `RSEQ_CLK_NS - 1) / `RSEQ_CLK_NS)
`define RSEQ_ACCEPT_CYC ((`RSEQ_ACCEPT_US * 1000) / `RSEQ_CLK_NS)
`define RSEQ_FILTER_CYC ((`RSEQ_FILTER_US * 1000) / `RSEQ_CLK_NS)

// ****************************************
// Sequence timing
// ****************************************
`define RSEQ_LOAD_MS 5
`define RSEQ_WAKE_MS 120
`define RSEQ_BLANK_MS 120
`define RSEQ_LOAD_CYC ((`RSEQ_LOAD_MS * 1000000) / `RSEQ_CLK_NS)
`define RSEQ_WAKE_CYC ((`RSEQ_WAKE_MS * 1000000) / `RSEQ_CLK_NS)
`define RSEQ_BLANK_CYC ((`RSEQ_BLANK_MS * 1000000) / `RSEQ_CLK_NS)

// ****************************************
// Nonvolatile image layout and reset values
// ****************************************
`define RSEQ_NVM_WORDS 3'h5
`define RSEQ_NVM_BASE 4'h0
`define RSEQ_IDX_ID0 3'h0
`define RSEQ_IDX_ID1 3'h1
`define RSEQ_IDX_ID2 3'h2
`define RSEQ_IDX_CVS 3'h3
`define RSEQ_IDX_MISC 3'h4
`define RSEQ_IMG_RESET 40'h0

`endif

//--- pkg/rst_seq_pkg.sv
// Types shared by the display hardware reset sequencer.
// Assumes the constants header is on the include path.
package rst_seq_pkg;

  typedef enum logic [2:0]
  {
    ST_RUN = 3'h0,
    ST_BLANKING = 3'h1,
    ST_HOLD = 3'h2,
    ST_LOAD = 3'h3,
    ST_DONE = 3'h4
  } seq_state_e;

  typedef struct packed
  {
    logic [23:0] id_bytes;
    logic [7:0] common_voltage_setting;
    logic [7:0] misc_setting;
  } nvm_image_s;

  typedef struct packed
  {
    seq_state_e state;
    logic [2:0] idx;
    logic busy;
    logic [20:0] blank_cnt;
  } seq_ctl_s;

endpackage : rst_seq_pkg

//--- verilog/spike_filter.sv
// Spike filter for the synchronised reset pin level.
// Assumes level_in is already synchronised to clk.
`timescale 1ns/1ps
`include "rst_seq_consts.svh"

module spike_filter
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic level_in,
  output logic level_out
);

  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic next_level;

  // ****************************************
  // Filter counter
  // ****************************************
  always_comb
  begin
    next_cnt = 7'h00;
    next_level = level_out;
    if (level_in != level_out)
    begin
      if (cnt == 7'(`RSEQ_FILTER_CYC - 1))
      begin
        next_level = level_in;
      end
      else
      begin
        next_cnt = cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 7'h00;
      level_out <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      level_out <= next_level;
    end
  end

endmodule : spike_filter

//--- verilog/display_hw_reset_sequencer.sv
// Hardware reset sequencer of a display controller.
// Assumes a 10 MHz clock, a raw reset pin and a same-clock nonvolatile read port.
`timescale 1ns/1ps
`include "rst_seq_consts.svh"

// Functional notes
// - Pin low pulses under 5 us are rejected and pulses over 9 us always reset.
// - High glitches inside a valid reset pulse are filtered the same way.
// - After each release the stored image is loaded within 5 ms of the filtered rising edge, or LOAD_FAIL is set at that deadline.
// - A reset that starts while awake runs a blanking phase of at most 120 ms.
// - A reset that starts while asleep keeps the display blank throughout.
// - A completed reset leaves the sequencer in ST_RUN, with the core released and the display unblanked.
module display_hw_reset_sequencer
  import rst_seq_pkg::*;
#(
  parameter int LOAD_CYCLES = `RSEQ_LOAD_CYC,
  parameter int WAKE_CYCLES = `RSEQ_WAKE_CYC,
  parameter int BLANK_CYCLES = `RSEQ_BLANK_CYC
)
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic HW_RESET_N,
  input wire logic SLEEP_OUT,
  input wire logic NVM_VALID,
  input wire logic [7:0] NVM_DATA,
  output logic NVM_RD,
  output logic [3:0] NVM_ADDR,
  output nvm_image_s NVM_IMAGE,
  output logic LOAD_FAIL,
  output logic CORE_RESET_N,
  output logic DISPLAY_BLANK,
  output logic CMD_READY,
  output logic WAKE_ALLOWED
);

  function automatic logic [20:0] sat_inc(input logic [20:0] v, input logic [20:0] lim);
    sat_inc = (v >= lim) ? v : v + 21'h000001;
  endfunction : sat_inc

  logic rst_meta;
  logic rst_n;
  logic pin_meta;
  logic pin_s;
  logic filt;
  seq_ctl_s ctl;
  seq_ctl_s next_ctl;
  nvm_image_s next_img;
  logic [20:0] rel_cnt;
  logic [20:0] next_rel;
  logic next_fail;
  logic next_rd;
  logic [3:0] next_addr;
  logic next_core;
  logic next_blank;
  logic next_cmd;
  logic next_wake;

  // ****************************************
  // Reset and pin synchronisers
  // ****************************************
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta <= 1'b0;
      pin_s <= 1'b0;
    end
    else
    begin
      pin_meta <= HW_RESET_N;
      pin_s <= pin_meta;
    end
  end

  spike_filter u_filter
  (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .level_in(pin_s),
    .level_out(filt)
  );

  // ****************************************
  // Sequence control
  // ****************************************
  always_comb
  begin
    next_ctl = ctl;
    next_img = NVM_IMAGE;
    next_fail = LOAD_FAIL;
    next_rd = 1'b0;
    next_addr = NVM_ADDR;
    next_rel = filt ? sat_inc(rel_cnt, 21'(WAKE_CYCLES)) : 21'h000000;
    case (ctl.state)
      ST_RUN:
      begin
        if (!filt)
        begin
          next_ctl.blank_cnt = 21'h000000;
          next_ctl.state = SLEEP_OUT ? ST_BLANKING : ST_HOLD;
        end
      end
      ST_BLANKING:
      begin
        next_ctl.blank_cnt = sat_inc(ctl.blank_cnt, 21'(BLANK_CYCLES));
        if (filt)
        begin
          next_ctl.state = ST_LOAD;
        end
        else if (ctl.blank_cnt >= 21'(BLANK_CYCLES - 1))
        begin
          next_ctl.state = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (filt)
        begin
          next_ctl.state = ST_LOAD;
        end
      end
      ST_LOAD:
      begin
        if (!filt)
        begin
          next_ctl.state = ST_HOLD;
        end
        else if (rel_cnt >= 21'(LOAD_CYCLES - 2))
        begin
          next_fail = 1'b1;
          next_ctl.state = ST_DONE;
        end
        else if (!ctl.busy)
        begin
          next_rd = 1'b1;
          next_addr = `RSEQ_NVM_BASE + {1'b0, ctl.idx};
          next_ctl.busy = 1'b1;
        end
        else if (NVM_VALID)
        begin
          case (ctl.idx)
            `RSEQ_IDX_ID0: next_img.id_bytes[23:16] = NVM_DATA;
            `RSEQ_IDX_ID1: next_img.id_bytes[15:8] = NVM_DATA;
            `RSEQ_IDX_ID2: next_img.id_bytes[7:0] = NVM_DATA;
            `RSEQ_IDX_CVS: next_img.common_voltage_setting = NVM_DATA;
            default: next_img.misc_setting = NVM_DATA;
          endcase
          next_ctl.busy = 1'b0;
          if (ctl.idx == `RSEQ_NVM_WORDS - 3'h1)
          begin
            next_ctl.state = ST_DONE;
          end
          else
          begin
            next_ctl.idx = ctl.idx + 3'h1;
          end
        end
      end
      ST_DONE:
      begin
        next_ctl.state = ST_RUN;
      end
      default:
      begin
        next_ctl.state = ST_HOLD;
      end
    endcase
    if (ctl.state != ST_LOAD && next_ctl.state == ST_LOAD)
    begin
      next_img = `RSEQ_IMG_RESET;
      next_fail = 1'b0;
      next_ctl.idx = 3'h0;
      next_ctl.busy = 1'b0;
    end
    next_core = (next_ctl.state == ST_RUN);
    next_blank = (next_ctl.state != ST_RUN);
    next_cmd = next_core && (next_rel >= 21'(LOAD_CYCLES));
    next_wake = next_core && (next_rel >= 21'(WAKE_CYCLES));
  end

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl <= '{state: ST_HOLD, idx: 3'h0, busy: 1'b0, blank_cnt: 21'h000000};
      NVM_IMAGE <= `RSEQ_IMG_RESET;
      LOAD_FAIL <= 1'b0;
      NVM_RD <= 1'b0;
      NVM_ADDR <= 4'h0;
      rel_cnt <= 21'h000000;
      CORE_RESET_N <= 1'b0;
      DISPLAY_BLANK <= 1'b1;
      CMD_READY <= 1'b0;
      WAKE_ALLOWED <= 1'b0;
    end
    else
    begin
      ctl <= next_ctl;
      NVM_IMAGE <= next_img;
      LOAD_FAIL <= next_fail;
      NVM_RD <= next_rd;
      NVM_ADDR <= next_addr;
      rel_cnt <= next_rel;
      CORE_RESET_N <= next_core;
      DISPLAY_BLANK <= next_blank;
      CMD_READY <= next_cmd;
      WAKE_ALLOWED <= next_wake;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [7:0] low_run;
  logic [7:0] high_run;

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_run <= 8'h00;
      high_run <= 8'h00;
    end
    else
    begin
      low_run <= pin_s ? 8'h00 : ((low_run == 8'hFF) ? low_run : low_run + 8'h01);
      high_run <= !pin_s ? 8'h00 : ((high_run == 8'hFF) ? high_run : high_run + 8'h01);
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!rst_n);

  sequence s_done;
    ctl.state == ST_DONE;
  endsequence

  sequence s_enter_load;
    (ctl.state == ST_HOLD) ##1 (ctl.state == ST_LOAD);
  endsequence

  a_short_reject: assert property ($fell(filt) |-> low_run >= `RSEQ_REJECT_CYC)
    else $error("reset accepted from a short pulse");
  a_long_accept: assert property (low_run >= `RSEQ_ACCEPT_CYC |-> !filt)
    else $error("long reset pulse not accepted");
  a_glitch_hold: assert property ($rose(filt) |-> high_run >= `RSEQ_REJECT_CYC)
    else $error("short high glitch ended the reset");
  a_load_deadline: assert property (ctl.state == ST_LOAD |-> rel_cnt < LOAD_CYCLES)
    else $error("image load ran past its deadline");
  a_load_finish: assert property ((ctl.state == ST_LOAD && ctl.busy && NVM_VALID && filt
    && ctl.idx == 3'h4 && rel_cnt < LOAD_CYCLES - 2) |=> s_done ##0 !LOAD_FAIL)
    else $error("last image word did not end the load");
  a_awake_blank: assert property ((ctl.state == ST_RUN && !filt && SLEEP_OUT)
    |=> ctl.state == ST_BLANKING && DISPLAY_BLANK)
    else $error("awake reset did not start blanking");
  a_blank_bound: assert property (ctl.state == ST_BLANKING |-> ctl.blank_cnt < BLANK_CYCLES)
    else $error("blanking phase too long");
  a_sleep_blank: assert property ((ctl.state == ST_RUN && !filt && !SLEEP_OUT)
    |=> ctl.state == ST_HOLD && DISPLAY_BLANK && !CORE_RESET_N)
    else $error("sleeping reset did not hold blank");
  a_reset_blank: assert property (!CORE_RESET_N |-> DISPLAY_BLANK)
    else $error("display shown during reset");
  a_default_done: assert property (s_done |=> ctl.state == ST_RUN && CORE_RESET_N
    && !DISPLAY_BLANK)
    else $error("reset did not return to default run");
  a_default_image: assert property (s_enter_load |-> NVM_IMAGE == `RSEQ_IMG_RESET
    && !LOAD_FAIL)
    else $error("image not defaulted before reload");

endmodule : display_hw_reset_sequencer

//--- bench/nvm_store_model.sv
// Nonvolatile store answering the sequencer read port.
// Assumes one outstanding read and a same-clock port.
`timescale 1ns/1ps
module nvm_store_model
(
  input wire logic clk,
  input wire logic rd,
  input wire logic [3:0] addr,
  input wire logic [39:0] image,
  input wire logic [7:0] delay,
  output logic valid,
  output logic [7:0] data
);
  int a;
  initial
  begin
    valid = 1'h0;
    data = 8'hA5;
  end
  // ****************************************
  // Read answer
  // ****************************************
  // stored image words
  always @(posedge clk)
  begin
    if (rd === 1'h1)
    begin
      a = addr;
      repeat (delay) @(posedge clk);
      #1;
      valid = 1'h1;
      data = image[39 - 8 * a -: 8];
      @(posedge clk);
      #1;
      valid = 1'h0;
      data = ~data;
    end
  end
endmodule : nvm_store_model

//--- bench/tb.sv
// Testbench for the display hardware reset sequencer.
// Assumes the design files and the store model are compiled first.
`timescale 1ns/1ps
module tb
  import rst_seq_pkg::*;
;
  localparam int LC = 200;
  localparam int WC = 600;
  logic CLK_SYS, RST_B, HW_RESET_N, SLEEP_OUT, NVM_VALID, NVM_RD, LOAD_FAIL;
  logic CORE_RESET_N, DISPLAY_BLANK, CMD_READY, WAKE_ALLOWED;
  logic [7:0] NVM_DATA;
  logic [7:0] dly;
  logic [3:0] NVM_ADDR;
  logic [39:0] img;
  nvm_image_s NVM_IMAGE;
  int num_errors, num_checks, t, seed;

  display_hw_reset_sequencer #(.LOAD_CYCLES(LC), .WAKE_CYCLES(WC), .BLANK_CYCLES(300)) i_dut
  (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .HW_RESET_N(HW_RESET_N), .SLEEP_OUT(SLEEP_OUT),
    .NVM_VALID(NVM_VALID), .NVM_DATA(NVM_DATA), .NVM_RD(NVM_RD), .NVM_ADDR(NVM_ADDR),
    .NVM_IMAGE(NVM_IMAGE), .LOAD_FAIL(LOAD_FAIL), .CORE_RESET_N(CORE_RESET_N),
    .DISPLAY_BLANK(DISPLAY_BLANK), .CMD_READY(CMD_READY), .WAKE_ALLOWED(WAKE_ALLOWED)
  );

  nvm_store_model i_store
  (
    .clk(CLK_SYS), .rd(NVM_RD), .addr(NVM_ADDR), .image(img), .delay(dly),
    .valid(NVM_VALID), .data(NVM_DATA)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  task automatic cyc(input int n);
    repeat (n)
    begin
      @(posedge CLK_SYS);
      #1;
      t++;
    end
  endtask : cyc

  task automatic new_image();
    int q[$];
    q = {};
    repeat (5) q.push_back($urandom_range(255));
    img = 40'h0;
    foreach (q[i]) img = {img[31:0], q[i][7:0]};
  endtask : new_image

  task automatic release_load(input logic slow);
    int n;
    n = 0;
    dly = slow ? 8'h3C : 8'($urandom_range(3));
    HW_RESET_N = 1'h1;
    t = 0;
    while (!(slow ? (LOAD_FAIL === 1'h1) : (CORE_RESET_N === 1'h1)) && n < 400)
    begin
      cyc(1);
      n++;
    end
    if (n == 400)
    begin
      num_errors++;
      complete_run();
    end
    if (slow)
      check(LOAD_FAIL, 1'h1);
    else
    begin
      check(NVM_IMAGE, img);
      check(LOAD_FAIL, 1'h0);
      check(NVM_ADDR, 4'h4);
      check(NVM_RD, 1'h0);
      check(DISPLAY_BLANK, 1'h0);
      cyc(72 + LC - 5 - t);
      check(CMD_READY, 1'h0);
      cyc(10);
      check(CMD_READY, 1'h1);
      cyc(WC - LC - 10);
      check(WAKE_ALLOWED, 1'h0);
      cyc(10);
      check(WAKE_ALLOWED, 1'h1);
    end
  endtask : release_load

  // ****************************************
  // Clock and sequence
  // ****************************************
  initial
  begin
    CLK_SYS = 1'h0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end

  initial
  begin
    RST_B = 1'h0;
    HW_RESET_N = 1'h1;
    SLEEP_OUT = 1'h0;
    dly = 8'h1;
    num_errors = 0;
    num_checks = 0;
    t = 0;
    seed = $urandom(32'h59e9);
    new_image();
    cyc(10);
    RST_B = 1'h1;
    release_load(1'h0);
    for (int m = 0; m < 4; m++)
    begin
      SLEEP_OUT = m[0];
      HW_RESET_N = 1'h0;
      cyc($urandom_range(45, 10));
      HW_RESET_N = 1'h1;
      cyc(100);
      check(CORE_RESET_N, 1'h1);
      check(NVM_IMAGE, img);
      new_image();
      HW_RESET_N = 1'h0;
      cyc(101);
      check(CORE_RESET_N, 1'h0);
      check(DISPLAY_BLANK, 1'h1);
      HW_RESET_N = 1'h1;
      cyc($urandom_range(45, 5));
      HW_RESET_N = 1'h0;
      cyc(60);
      check(CORE_RESET_N, 1'h0);
      cyc((m == 1) ? 400 : 20);
      check(DISPLAY_BLANK, 1'h1);
      release_load(m == 2);
      if (m == 2)
      begin
        HW_RESET_N = 1'h0;
        cyc(101);
        release_load(1'h0);
      end
    end
    complete_run();
  end
endmodule : tb
